// >>> rtl/csb_pkg.sv
// Shared encodings, constants and carrier types of the stack, rotate and branch slice.
package csb_pkg;

    // Opcodes handled by this slice.
    localparam logic [7:0] OPC_OR_DIR_A = 8'h42;
    localparam logic [7:0] OPC_OR_DIR_IMM = 8'h43;
    localparam logic [7:0] OPC_OR_C_BIT = 8'h72;
    localparam logic [7:0] OPC_OR_C_NBIT = 8'hA0;
    localparam logic [7:0] OPC_STACK_PULL = 8'hD0;
    localparam logic [7:0] OPC_STACK_PLACE = 8'hC0;
    localparam logic [7:0] OPC_SUBROUTINE_EXIT = 8'h22;
    localparam logic [7:0] OPC_INTERRUPT_EXIT = 8'h32;
    localparam logic [7:0] OPC_ROTATE_LEFT = 8'h23;
    localparam logic [7:0] OPC_ROTATE_LEFT_C = 8'h33;
    localparam logic [7:0] OPC_ROTATE_RIGHT = 8'h03;
    localparam logic [7:0] OPC_ROTATE_RIGHT_C = 8'h13;
    localparam logic [7:0] OPC_FORCE_CARRY = 8'hD3;
    localparam logic [7:0] OPC_FORCE_BIT = 8'hD2;
    localparam logic [7:0] OPC_SHORT_BRANCH = 8'h80;

    // Direct address of the stack pointer and base of the bit-addressable RAM.
    localparam logic [7:0] SP_DIRECT_ADDR = 8'h81;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;

    // Step sizes.
    localparam logic [7:0] SP_STEP = 8'h01;
    localparam logic [15:0] BRANCH_STEP = 16'h0002;

    typedef enum logic [3:0] {
        OP_OR_DIR_A,
        OP_OR_DIR_IMM,
        OP_OR_C_BIT,
        OP_OR_C_NBIT,
        OP_STACK_PULL,
        OP_STACK_PLACE,
        OP_SUBROUTINE_EXIT,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_C,
        OP_ROTATE_RIGHT,
        OP_ROTATE_RIGHT_C,
        OP_FORCE_CARRY,
        OP_FORCE_BIT,
        OP_SHORT_BRANCH,
        OP_NONE
    } csb_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXEC,
        ST_READ,
        ST_WAIT,
        ST_READ_LO,
        ST_WAIT_LO,
        ST_WRITE,
        ST_DONE
    } csb_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic indirect;
        logic latch;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csb_mem_req_t;

    typedef struct packed {
        logic acc_wr;
        logic [7:0] acc;
        logic cy_wr;
        logic cy;
        logic sp_wr;
        logic [7:0] sp;
        logic pc_wr;
        logic [15:0] pc;
    } csb_core_upd_t;

endpackage

// >>> rtl/csb_alu.sv
// Combinational data path for the OR, rotate and bit-force operations.
module csb_alu (
    // Operation and operands
    input wire csb_pkg::csb_op_t op,
    input wire logic [7:0] acc,
    input wire logic cy,
    input wire logic [7:0] byte_in,
    input wire logic [7:0] imm,
    input wire logic [7:0] bit_addr,
    // Results
    output logic [7:0] res_byte,
    output logic [7:0] res_acc,
    output logic res_cy,
    output logic [7:0] bit_byte_addr
);
    import csb_pkg::*;

    logic [2:0] bit_pos;
    logic bit_val;
    logic [7:0] bit_mask;

    assign bit_pos = bit_addr[2:0];
    assign bit_val = byte_in[bit_pos];
    assign bit_mask = 8'h01 << bit_pos;
    // Bit addresses below the top half live in the bit-addressable RAM bytes.
    assign bit_byte_addr = bit_addr[7] ? {bit_addr[7:3], 3'h0}
                                       : BIT_AREA_BASE + {4'h0, bit_addr[6:3]};

    assign res_byte = (op == OP_FORCE_BIT) ? (byte_in | bit_mask) :
                      (op == OP_OR_DIR_IMM) ? (byte_in | imm) :
                      (byte_in | acc);

    assign res_acc = (op == OP_ROTATE_LEFT) ? {acc[6:0], acc[7]} :
                     (op == OP_ROTATE_LEFT_C) ? {acc[6:0], cy} :
                     (op == OP_ROTATE_RIGHT) ? {acc[0], acc[7:1]} :
                     (op == OP_ROTATE_RIGHT_C) ? {cy, acc[7:1]} :
                     acc;

    assign res_cy = (op == OP_ROTATE_LEFT_C) ? acc[7] :
                    (op == OP_ROTATE_RIGHT_C) ? acc[0] :
                    (op == OP_OR_C_BIT) ? (cy | bit_val) :
                    (op == OP_OR_C_NBIT) ? (cy | ~bit_val) :
                    (op == OP_FORCE_CARRY) ? 1'b1 :
                    cy;

endmodule

// >>> rtl/csb_exec.sv
// Execution sequencer for the OR, stack, exit, rotate, bit-force and short branch instructions.
// What this block does
// - OR accumulator into direct byte, write back.
// - OR immediate constant into direct byte.
// - Carry set when addressed bit is one.
// - Complemented form uses inverted bit, bit untouched.
// - Pull reads stack, decrements pointer, writes destination.
// - Pull into stack pointer: pulled value wins.
// - Place increments pointer, then stores direct byte.
// - Subroutine exit pops PC high, low; minus two.
// - Interrupt exit restores PC, releases priority level.
// - Interrupt exit touches only PC and pointer.
// - After interrupt exit, one instruction before vectoring.
// - Rotate left, bit 7 into bit 0.
// - Rotate left through carry.
// - Rotate right, bit 0 into bit 7.
// - Rotate right through carry.
// - Force carry or addressed bit to one.
// - Branch to PC plus two plus signed displacement.
// - OR on port reads output latch, not pins.
module csb_exec (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Instruction from fetch
    input wire logic instr_valid,
    input wire logic [7:0] instr_opcode,
    input wire logic [7:0] instr_arg1,
    input wire logic [7:0] instr_arg2,
    input wire logic [15:0] instr_pc,
    output logic instr_ready,
    // Core state in and updates out
    input wire logic [7:0] acc_in,
    input wire logic carry_in,
    input wire logic [7:0] sp_in,
    output csb_pkg::csb_core_upd_t upd,
    output logic done,
    output logic illegal,
    // Internal RAM and special register access
    output csb_pkg::csb_mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    // Interrupt logic
    input wire logic irq_pending_le,
    input wire logic instr_retired,
    output logic irq_level_release,
    output logic irq_vector_hold
);
    import csb_pkg::*;

    csb_state_t state;
    csb_state_t next_state;
    csb_op_t op;
    csb_op_t next_op;
    csb_op_t dec_op;
    logic [7:0] arg1;
    logic [7:0] next_arg1;
    logic [7:0] arg2;
    logic [7:0] next_arg2;
    logic [15:0] pc_base;
    logic [15:0] next_pc_base;
    logic [7:0] sp;
    logic [7:0] next_sp;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic cy;
    logic next_cy;
    logic [7:0] data;
    logic [7:0] next_data;
    logic [7:0] pc_hi;
    logic [7:0] next_pc_hi;
    csb_core_upd_t next_upd;
    logic next_illegal;
    logic next_release;
    logic next_hold;
    logic [7:0] alu_byte;
    logic [7:0] alu_acc;
    logic alu_cy;
    logic [7:0] alu_bit_addr;
    logic [15:0] branch_target;
    logic stack_side;
    logic bit_side;
    logic rmw_side;
    logic interrupt_exit_done;

    assign dec_op = (instr_opcode == OPC_OR_DIR_A) ? OP_OR_DIR_A :
                    (instr_opcode == OPC_OR_DIR_IMM) ? OP_OR_DIR_IMM :
                    (instr_opcode == OPC_OR_C_BIT) ? OP_OR_C_BIT :
                    (instr_opcode == OPC_OR_C_NBIT) ? OP_OR_C_NBIT :
                    (instr_opcode == OPC_STACK_PULL) ? OP_STACK_PULL :
                    (instr_opcode == OPC_STACK_PLACE) ? OP_STACK_PLACE :
                    (instr_opcode == OPC_SUBROUTINE_EXIT) ? OP_SUBROUTINE_EXIT :
                    (instr_opcode == OPC_INTERRUPT_EXIT) ? OP_INTERRUPT_EXIT :
                    (instr_opcode == OPC_ROTATE_LEFT) ? OP_ROTATE_LEFT :
                    (instr_opcode == OPC_ROTATE_LEFT_C) ? OP_ROTATE_LEFT_C :
                    (instr_opcode == OPC_ROTATE_RIGHT) ? OP_ROTATE_RIGHT :
                    (instr_opcode == OPC_ROTATE_RIGHT_C) ? OP_ROTATE_RIGHT_C :
                    (instr_opcode == OPC_FORCE_CARRY) ? OP_FORCE_CARRY :
                    (instr_opcode == OPC_FORCE_BIT) ? OP_FORCE_BIT :
                    (instr_opcode == OPC_SHORT_BRANCH) ? OP_SHORT_BRANCH :
                    OP_NONE;

    csb_alu u_alu (
        .op(op),
        .acc(acc),
        .cy(cy),
        .byte_in(mem_rdata),
        .imm(arg2),
        .bit_addr(arg1),
        .res_byte(alu_byte),
        .res_acc(alu_acc),
        .res_cy(alu_cy),
        .bit_byte_addr(alu_bit_addr)
    );

    assign branch_target = pc_base + BRANCH_STEP + {{8{arg2[7]}}, arg2};

    // Memory address selection.
    assign stack_side = (state == ST_WRITE) ? (op == OP_STACK_PLACE)
                        : (op == OP_STACK_PULL || op == OP_SUBROUTINE_EXIT
                           || op == OP_INTERRUPT_EXIT);
    assign bit_side = (op == OP_OR_C_BIT) || (op == OP_OR_C_NBIT) || (op == OP_FORCE_BIT);
    assign rmw_side = (op == OP_OR_DIR_A) || (op == OP_OR_DIR_IMM) || (op == OP_FORCE_BIT);
    assign mem_req.rd = (state == ST_READ) || (state == ST_READ_LO);
    assign mem_req.wr = (state == ST_WRITE);
    assign mem_req.indirect = stack_side;
    // A read-modify-write must see the port latch, or input pins would leak into it.
    assign mem_req.latch = mem_req.rd && rmw_side;
    assign mem_req.addr = stack_side ? sp : (bit_side ? alu_bit_addr : arg1);
    assign mem_req.wdata = data;

    assign instr_ready = (state == ST_IDLE);
    assign done = (state == ST_DONE);
    assign interrupt_exit_done = done && (op == OP_INTERRUPT_EXIT);

    always_comb begin
        next_state = state;
        next_op = op;
        next_arg1 = arg1;
        next_arg2 = arg2;
        next_pc_base = pc_base;
        next_sp = sp;
        next_acc = acc;
        next_cy = cy;
        next_data = data;
        next_pc_hi = pc_hi;
        next_upd = upd;
        next_illegal = illegal;
        next_release = irq_level_release;
        case (state)
            ST_IDLE: begin
                if (instr_valid) begin
                    next_op = dec_op;
                    next_arg1 = instr_arg1;
                    next_arg2 = instr_arg2;
                    next_pc_base = instr_pc;
                    next_sp = sp_in;
                    next_acc = acc_in;
                    next_cy = carry_in;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state = ST_READ;
                case (op)
                    OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                        next_upd.acc_wr = 1'b1;
                        next_upd.acc = alu_acc;
                        next_state = ST_DONE;
                    end
                    OP_ROTATE_LEFT_C, OP_ROTATE_RIGHT_C: begin
                        next_upd.acc_wr = 1'b1;
                        next_upd.acc = alu_acc;
                        next_upd.cy_wr = 1'b1;
                        next_upd.cy = alu_cy;
                        next_state = ST_DONE;
                    end
                    OP_FORCE_CARRY: begin
                        next_upd.cy_wr = 1'b1;
                        next_upd.cy = alu_cy;
                        next_state = ST_DONE;
                    end
                    OP_SHORT_BRANCH: begin
                        next_upd.pc_wr = 1'b1;
                        next_upd.pc = branch_target;
                        next_state = ST_DONE;
                    end
                    OP_STACK_PLACE: begin
                        next_sp = sp + SP_STEP;
                    end
                    OP_NONE: begin
                        next_illegal = 1'b1;
                        next_state = ST_DONE;
                    end
                    default: begin
                    end
                endcase
            end
            ST_READ: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                case (op)
                    OP_OR_C_BIT, OP_OR_C_NBIT: begin
                        next_upd.cy_wr = 1'b1;
                        next_upd.cy = alu_cy;
                        next_state = ST_DONE;
                    end
                    OP_STACK_PULL: begin
                        next_sp = sp - SP_STEP;
                        if (arg1 == SP_DIRECT_ADDR) begin
                            next_upd.sp_wr = 1'b1;
                            next_upd.sp = mem_rdata;
                            next_state = ST_DONE;
                        end else begin
                            next_data = mem_rdata;
                            next_state = ST_WRITE;
                        end
                    end
                    OP_STACK_PLACE: begin
                        next_data = mem_rdata;
                        next_state = ST_WRITE;
                    end
                    OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                        next_pc_hi = mem_rdata;
                        next_sp = sp - SP_STEP;
                        next_state = ST_READ_LO;
                    end
                    default: begin
                        next_data = alu_byte;
                        next_state = ST_WRITE;
                    end
                endcase
            end
            ST_READ_LO: begin
                next_state = ST_WAIT_LO;
            end
            ST_WAIT_LO: begin
                // Only the program counter and the pointer change here.
                next_upd.pc_wr = 1'b1;
                next_upd.pc = {pc_hi, mem_rdata};
                next_upd.sp_wr = 1'b1;
                next_upd.sp = sp - SP_STEP;
                next_release = (op == OP_INTERRUPT_EXIT);
                next_state = ST_DONE;
            end
            ST_WRITE: begin
                if (op == OP_STACK_PULL || op == OP_STACK_PLACE) begin
                    next_upd.sp_wr = 1'b1;
                    next_upd.sp = sp;
                end
                next_state = ST_DONE;
            end
            ST_DONE: begin
                next_upd = '0;
                next_illegal = 1'b0;
                next_release = 1'b0;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // The hold is set by the exit itself and dropped when any later instruction retires.
    assign next_hold = (state == ST_WAIT_LO && op == OP_INTERRUPT_EXIT && irq_pending_le)
                       ? 1'b1
                       : (((instr_retired || done) && !interrupt_exit_done) ? 1'b0 : irq_vector_hold);

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            op <= OP_NONE;
            upd <= '0;
            illegal <= 1'b0;
            irq_level_release <= 1'b0;
            irq_vector_hold <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            op <= next_op;
            upd <= next_upd;
            illegal <= next_illegal;
            irq_level_release <= next_release;
            irq_vector_hold <= next_hold;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arg1 <= 8'h00;
            arg2 <= 8'h00;
            pc_base <= 16'h0000;
            sp <= 8'h00;
            acc <= 8'h00;
            cy <= 1'b0;
            data <= 8'h00;
            pc_hi <= 8'h00;
        end else if (ce) begin
            arg1 <= next_arg1;
            arg2 <= next_arg2;
            pc_base <= next_pc_base;
            sp <= next_sp;
            acc <= next_acc;
            cy <= next_cy;
            data <= next_data;
            pc_hi <= next_pc_hi;
        end
    end

    // Helper state seen only by the checks below.
    logic [7:0] chk_sp_start;
    logic [7:0] chk_rdata;
    always_ff @(posedge clk) begin
        if (rst) begin
            chk_sp_start <= 8'h00;
            chk_rdata <= 8'h00;
        end else if (ce) begin
            if (state == ST_IDLE && instr_valid) begin
                chk_sp_start <= sp_in;
            end
            if (state == ST_WAIT) begin
                chk_rdata <= mem_rdata;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_or_acc_write: assert property (mem_req.wr && op == OP_OR_DIR_A |-> mem_req.wdata == (chk_rdata | acc)) else $error("OR with accumulator wrote wrong byte");
    chk_or_imm_write: assert property (mem_req.wr && op == OP_OR_DIR_IMM |-> mem_req.wdata == (chk_rdata | arg2)) else $error("OR with constant wrote wrong byte");
    chk_or_carry: assert property (done && op == OP_OR_C_BIT |-> upd.cy_wr && upd.cy == (cy | chk_rdata[arg1[2:0]]) && !upd.acc_wr) else $error("OR to carry wrong");
    chk_or_ncarry: assert property (done && op == OP_OR_C_NBIT |-> upd.cy == (cy | ~chk_rdata[arg1[2:0]]) && !mem_req.wr) else $error("Complemented OR to carry wrong");
    chk_pull_step: assert property (state == ST_WAIT && op == OP_STACK_PULL && ce |=> sp == chk_sp_start - SP_STEP) else $error("Pull did not decrement pointer");
    chk_pull_self: assert property (done && op == OP_STACK_PULL && arg1 == SP_DIRECT_ADDR |-> upd.sp_wr && upd.sp == chk_rdata) else $error("Pull into pointer lost pulled value");
    chk_place_addr: assert property (mem_req.wr && op == OP_STACK_PLACE |-> mem_req.indirect && mem_req.addr == chk_sp_start + SP_STEP) else $error("Place used wrong address");
    chk_exit_net: assert property (done && (op == OP_SUBROUTINE_EXIT || op == OP_INTERRUPT_EXIT) |-> upd.sp == chk_sp_start - 8'h02 && upd.pc_wr) else $error("Exit pointer not minus two");
    chk_release_pulse: assert property (done |-> irq_level_release == (op == OP_INTERRUPT_EXIT)) else $error("Level release wrong");
    chk_exit_only_pc: assert property (interrupt_exit_done |-> !upd.acc_wr && !upd.cy_wr && !illegal) else $error("Interrupt exit touched other state");
    chk_hold_after: assert property (state == ST_WAIT_LO && op == OP_INTERRUPT_EXIT && irq_pending_le && ce |=> irq_vector_hold [*1] ##0 done) else $error("Vector hold not set after exit");
    chk_rot_left: assert property (done && op == OP_ROTATE_LEFT |-> upd.acc == {acc[6:0], acc[7]} && !upd.cy_wr) else $error("Rotate left wrong");
    chk_rot_left_c: assert property (done && op == OP_ROTATE_LEFT_C |-> upd.acc == {acc[6:0], cy} && upd.cy == acc[7]) else $error("Rotate left through carry wrong");
    chk_rot_right: assert property (done && op == OP_ROTATE_RIGHT |-> upd.acc == {acc[0], acc[7:1]} && !upd.cy_wr) else $error("Rotate right wrong");
    chk_rot_right_c: assert property (done && op == OP_ROTATE_RIGHT_C |-> upd.acc == {cy, acc[7:1]} && upd.cy == acc[0]) else $error("Rotate right through carry wrong");
    chk_force_carry: assert property (done && op == OP_FORCE_CARRY |-> upd.cy_wr && upd.cy && !upd.acc_wr) else $error("Force carry wrong");
    chk_branch_target: assert property (done && op == OP_SHORT_BRANCH |-> upd.pc == pc_base + 16'h0002 + {{8{arg2[7]}}, arg2}) else $error("Branch target wrong");
    chk_latch_read: assert property (mem_req.rd |-> mem_req.latch == (op == OP_OR_DIR_A || op == OP_OR_DIR_IMM || op == OP_FORCE_BIT) && !(mem_req.latch && mem_req.indirect)) else $error("Read-modify-write not from latch");
    chk_decode_pull: assert property (state == ST_IDLE && instr_valid && instr_opcode == 8'hD0 && ce |=> op == OP_STACK_PULL) else $error("Pull opcode not decoded");

    cov_interrupt_exit: cover property (interrupt_exit_done && irq_vector_hold);
    cov_pull_self: cover property (done && op == OP_STACK_PULL && arg1 == SP_DIRECT_ADDR);
    cov_branch_back: cover property (done && op == OP_SHORT_BRANCH && arg2[7]);
    cov_force_bit: cover property (mem_req.wr && op == OP_FORCE_BIT);

endmodule

// >>> testbench/csb_exec_tb.sv
// Self-checking bench for the OR, stack, exit, rotate, bit-force and short branch slice.
module csb_exec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import csb_pkg::*;

    typedef struct packed {
        logic [7:0] op, a1, a2, a;
        logic c;
        logic [7:0] s;
        logic [3:0] fl;
        logic [7:0] wa, wd;
        logic [15:0] ev;
        logic [7:0] es;
    } csb_row_t;

    logic clk, rst, ce, instr_valid, instr_ready, carry_in, done, illegal;
    logic [7:0] instr_opcode, instr_arg1, instr_arg2, acc_in, sp_in, mem_rdata;
    logic [15:0] instr_pc;
    logic irq_pending_le, instr_retired, irq_level_release, irq_vector_hold;
    csb_core_upd_t upd, s_upd;
    csb_mem_req_t mem_req;
    logic [7:0] mem [256];
    logic [7:0] wa_seen, wd_seen, rd_addr;
    logic rd_pend, s_ill, s_rel, lat_seen;
    int n_fail = 0;
    int compares = 0;

    // Flags are {acc, carry, pointer, pc}; carry is expected in ev[8].
    csb_row_t rows [20] = '{
        '{8'h42, 8'h30, 8'h00, 8'h81, 1'b0, 8'h40, 4'h0, 8'h30, 8'hDB, 16'h0000, 8'h00},
        '{8'h43, 8'h30, 8'h0C, 8'h00, 1'b0, 8'h40, 4'h0, 8'h30, 8'h5E, 16'h0000, 8'h00},
        '{8'h72, 8'h20, 8'h00, 8'h00, 1'b0, 8'h40, 4'h4, 8'h00, 8'h00, 16'h0100, 8'h00},
        '{8'h72, 8'h21, 8'h00, 8'h00, 1'b0, 8'h40, 4'h4, 8'h00, 8'h00, 16'h0000, 8'h00},
        '{8'hA0, 8'h21, 8'h00, 8'h00, 1'b0, 8'h40, 4'h4, 8'h00, 8'h00, 16'h0100, 8'h00},
        '{8'hA0, 8'h20, 8'h00, 8'h00, 1'b0, 8'h40, 4'h4, 8'h00, 8'h00, 16'h0000, 8'h00},
        '{8'hD0, 8'h30, 8'h00, 8'h00, 1'b0, 8'h40, 4'h2, 8'h30, 8'h01, 16'h0000, 8'h3F},
        '{8'hD0, 8'h81, 8'h00, 8'h00, 1'b0, 8'h40, 4'h2, 8'h00, 8'h00, 16'h0000, 8'h01},
        '{8'hC0, 8'h30, 8'h00, 8'h00, 1'b0, 8'h40, 4'h2, 8'h41, 8'h5A, 16'h0000, 8'h41},
        '{8'h22, 8'h00, 8'h00, 8'h00, 1'b0, 8'h40, 4'h3, 8'h00, 8'h00, 16'h0123, 8'h3E},
        '{8'h32, 8'h00, 8'h00, 8'h00, 1'b0, 8'h40, 4'h3, 8'h00, 8'h00, 16'h0123, 8'h3E},
        '{8'h23, 8'h00, 8'h00, 8'hC5, 1'b0, 8'h40, 4'h8, 8'h00, 8'h00, 16'h008B, 8'h00},
        '{8'h33, 8'h00, 8'h00, 8'hC5, 1'b0, 8'h40, 4'hC, 8'h00, 8'h00, 16'h018A, 8'h00},
        '{8'h03, 8'h00, 8'h00, 8'hC5, 1'b0, 8'h40, 4'h8, 8'h00, 8'h00, 16'h00E2, 8'h00},
        '{8'h13, 8'h00, 8'h00, 8'hC5, 1'b0, 8'h40, 4'hC, 8'h00, 8'h00, 16'h0162, 8'h00},
        '{8'hD3, 8'h00, 8'h00, 8'h00, 1'b0, 8'h40, 4'h4, 8'h00, 8'h00, 16'h0100, 8'h00},
        '{8'hD2, 8'h21, 8'h00, 8'h00, 1'b0, 8'h40, 4'h0, 8'h24, 8'h07, 16'h0000, 8'h00},
        '{8'h80, 8'h00, 8'h21, 8'h00, 1'b0, 8'h40, 4'h1, 8'h00, 8'h00, 16'h0123, 8'h00},
        '{8'h80, 8'h00, 8'h80, 8'h00, 1'b0, 8'h40, 4'h1, 8'h00, 8'h00, 16'h0082, 8'h00},
        '{8'h80, 8'h00, 8'h7F, 8'h00, 1'b0, 8'h40, 4'h1, 8'h00, 8'h00, 16'h0181, 8'h00}
    };

    csb_exec DUT (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .instr_arg1(instr_arg1), .instr_arg2(instr_arg2),
        .instr_pc(instr_pc), .instr_ready(instr_ready), .acc_in(acc_in), .carry_in(carry_in),
        .sp_in(sp_in), .upd(upd), .done(done), .illegal(illegal), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .irq_pending_le(irq_pending_le), .instr_retired(instr_retired),
        .irq_level_release(irq_level_release), .irq_vector_hold(irq_vector_hold));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Read data is valid only in the cycle after a read; otherwise it shows garbage.
    always @(negedge clk) begin
        if (instr_valid === 1'b1) begin
            wa_seen <= 8'h00;
            lat_seen <= 1'b0;
        end else if (mem_req.wr === 1'b1) begin
            wa_seen <= mem_req.addr;
            wd_seen <= mem_req.wdata;
        end else if (mem_req.rd === 1'b1) begin
            lat_seen <= lat_seen | mem_req.latch;
        end
        rd_pend <= mem_req.rd;
        rd_addr <= mem_req.addr;
    end
    always @(posedge clk) begin
        #1;
        mem_rdata = (rd_pend === 1'b1) ? mem[rd_addr] : ~mem_rdata;
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic run(input csb_row_t r);
        int n;
        @(posedge clk);
        #1;
        {instr_opcode, instr_arg1, instr_arg2, acc_in, carry_in, sp_in} = {r.op, r.a1, r.a2, r.a, r.c, r.s};
        instr_pc = 16'h0100;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (done === 1'b1) break;
        end
        if (n == 20) begin
            n_fail++;
            $display("wrong value at %0t: no done within limit", $time);
        end
        {s_upd, s_ill, s_rel} = {upd, illegal, irq_level_release};
    endtask

    initial begin
        {rst, ce, instr_valid, instr_opcode, instr_arg1, instr_arg2} = {2'b11, 25'h0};
        {instr_pc, acc_in, carry_in, sp_in} = 33'h0;
        {irq_pending_le, instr_retired} = 2'b00;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        {mem[8'h30], mem[8'h40], mem[8'h3F], mem[8'h24]} = {8'h5A, 8'h01, 8'h23, 8'h05};
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        chk_bit(instr_ready, 1'b1);
        chk_bit(done, 1'b0);
        foreach (rows[i]) begin
            run(rows[i]);
            chk_val(16'({s_upd.acc_wr, s_upd.cy_wr, s_upd.sp_wr, s_upd.pc_wr}), 16'(rows[i].fl));
            if (rows[i].fl[3]) chk_val(16'(s_upd.acc), 16'(rows[i].ev[7:0]));
            if (rows[i].fl[2]) chk_bit(s_upd.cy, rows[i].ev[8]);
            if (rows[i].fl[1]) chk_val(16'(s_upd.sp), 16'(rows[i].es));
            if (rows[i].fl[0]) chk_val(s_upd.pc, rows[i].ev);
            chk_val(16'(wa_seen), 16'(rows[i].wa));
            if (rows[i].wa != 8'h00) chk_val(16'(wd_seen), 16'(rows[i].wd));
            chk_bit(lat_seen, (rows[i].op == 8'h42) || (rows[i].op == 8'h43)
                || (rows[i].op == 8'hD2));
            chk_bit(irq_vector_hold, 1'b0);
        end
        // Unknown opcode must not touch any core state.
        run('{8'hA5, 8'h00, 8'h00, 8'h00, 1'b0, 8'h40, 4'h0, 8'h00, 8'h00, 16'h0, 8'h00});
        chk_bit(s_ill, 1'b1);
        chk_val(16'({s_upd.acc_wr, s_upd.cy_wr, s_upd.sp_wr, s_upd.pc_wr}), 16'h0000);
        irq_pending_le = 1'b1;
        run(rows[10]);
        chk_bit(s_rel, 1'b1);
        chk_bit(irq_vector_hold, 1'b1);
        run(rows[11]);
        chk_bit(irq_vector_hold, 1'b1);
        @(posedge clk);
        #1;
        chk_bit(irq_vector_hold, 1'b0);
        // A low clock enable must freeze an accepted instruction, not drop it.
        fork
            run(rows[11]);
            begin
                repeat (2) @(posedge clk);
                #1;
                ce = 1'b0;
                repeat (3) begin
                    @(posedge clk);
                    #1;
                    chk_bit(done, 1'b0);
                end
                ce = 1'b1;
            end
        join
        chk_val(16'(s_upd.acc), 16'h008B);
        // Reset in mid-instruction must leave nothing pending.
        @(posedge clk);
        #1;
        {instr_opcode, instr_valid} = {8'h22, 1'b1};
        @(posedge clk);
        #1;
        {instr_valid, rst} = 2'b01;
        @(posedge clk);
        #1;
        rst = 1'b0;
        chk_val(16'({instr_ready, done, illegal, irq_vector_hold, mem_req.rd, mem_req.wr}), 16'h0020);
        run(rows[11]);
        chk_val(16'(s_upd.acc), 16'h008B);
        give_verdict();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        $display("wrong value at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
